// ### include/fsr_pkg.sv
// Constants and types shared by the fail-safe release sequencer.
package fsr_pkg;

  // Host register data width
  localparam int unsigned DATA_W          = 16;
  // Debug-exit bit position in the fail-safe state register
  localparam int unsigned DBG_EXIT_BIT    = 14;
  // Window period field of the window duration register
  localparam int unsigned WIN_PERIOD_LSB  = 11;
  localparam int unsigned WIN_PERIOD_W    = 5;
  localparam logic [4:0]  WIN_PERIOD_OFF  = 5'h00;
  // Bits 7:4 are reserved and left out of the inverse pair check
  localparam logic [15:0] WIN_PAIR_MASK   = 16'hFF0F;
  // Configuration bit that enables watchdog windowing
  localparam int unsigned CFG_WDW_EN_BIT  = 0;
  // Keys and answers
  localparam logic [15:0] GOOD_ANSWER     = 16'h5AB2;
  localparam logic [15:0] RELEASE_KEY     = 16'hB2A5;
  // Fault counter width and value after reset
  localparam int unsigned FAULT_W         = 3;
  localparam logic [2:0]  FAULT_RST       = 3'h6;
  localparam logic [2:0]  FAULT_MAX       = 3'h7;
  // Reset values of held registers
  localparam logic [15:0] DUR_RST         = 16'h0000;
  localparam logic [15:0] INV_RST         = 16'hFFFF;
  localparam logic [15:0] CFG_RST         = 16'h0000;

  // Fail-safe state machine
  typedef enum logic [2:0] {
    FSR_STARTUP    = 3'b000,
    FSR_FUSE_MODE  = 3'b001,
    FSR_INIT       = 3'b010,
    FSR_NORMAL     = 3'b011,
    FSR_START_FAIL = 3'b100
  } fsr_state_e;

endpackage

// ### src/fsr_failsafe_release_sequencer.sv
// Start-up configuration choice, fail-safe init and safety output release.

// Overview of operation
// RULE1: Operating configuration always comes from the mirror register, not fuses.
// RULE2: Mirror filled from fuse data or from a direct host write.
// RULE3: Regulators stay off while in fuse programming mode.
// RULE4: Fuse-mode exit with a valid configuration starts regulators, enters init.
// RULE5: A host-written mirror configuration is kept for the session.
// RULE6: Unwritten mirror takes the burned fuse configuration when present.
// RULE7: No written and no fused configuration means start-up fails.
// RULE8: Debug mode blocks release; writing debug-exit bit as 1 leaves it.
// RULE9: Zero window period field disables watchdog windowing.
// RULE10: Window duration and its inverse form a checked pair.
// RULE11: First good watchdog answer closes the init phase.
// RULE12: Good answers after debug exit count the fault counter down to 0.
// RULE13: Release key write releases the safety output high.
// RULE14: Release accepted only when fused configuration enables windowing; the code checks the mirror bit, host-written or fused.
// RULE15: Debug mode disables windowing, init timeout and safety reactions.
// RULE16: Entering fuse programming mode also enables debug mode.
// RULE17: Fuse-mode exit command or debug pin removal starts power-up.
// RULE18: A flag records whether the host wrote the mirror since reset.
module fsr_failsafe_release_sequencer
  import fsr_pkg::*;
#(
  parameter int unsigned CFG_W = 16
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Debug entry pin, asynchronous
  input  wire logic              debug_entry_pin_i,
  // Fuse array contents
  input  wire logic              fuse_valid_i,
  input  wire logic [CFG_W-1:0]  fuse_cfg_i,
  // Host write strobes, one cycle each; mirror writes take mirror_data_i, the others share wr_data_i
  input  wire logic [DATA_W-1:0] wr_data_i,
  input  wire logic [CFG_W-1:0]  mirror_data_i,
  input  wire logic              wr_mirror_i,
  input  wire logic              wr_state_reg_i,
  input  wire logic              wr_window_dur_i,
  input  wire logic              wr_window_inv_i,
  input  wire logic              wr_answer_i,
  input  wire logic              wr_release_i,
  input  wire logic              exit_fuse_mode_i,
  // Status and control outputs
  output logic [2:0]             failsafe_state_o,
  output logic                   debug_mode_o,
  output logic                   regulators_en_o,
  output logic                   startup_fail_o,
  output logic [CFG_W-1:0]       active_cfg_o,
  output logic                   mirror_written_o,
  output logic [WIN_PERIOD_W-1:0] window_period_o,
  output logic                   window_cfg_ok_o,
  output logic                   windowing_active_o,
  output logic [FAULT_W-1:0]     fault_cnt_o,
  output logic                   safety_output_pin_o
);

  fsr_state_e              state_r;
  logic                    pin_meta_r;
  logic                    pin_sync_r;
  logic                    debug_r;
  logic                    written_r;
  logic [CFG_W-1:0]        mirror_r;
  logic [DATA_W-1:0]       dur_r;
  logic [DATA_W-1:0]       inv_r;
  logic [FAULT_W-1:0]      fault_r;
  logic                    release_r;
  logic                    leave_fuse;
  logic                    pair_ok;
  logic                    good_ans;
  logic                    bad_ans;
  logic                    release_ok;

  // Two flops before the pin is looked at; meta flop feeds sync flop only.
  // Kept out of reset so the strap has settled when reset lifts.
  always_ff @(posedge clk_i) begin
    pin_meta_r <= debug_entry_pin_i;
    pin_sync_r <= pin_meta_r;
  end

  // Exit triggers out of fuse mode
  assign leave_fuse = (state_r == FSR_FUSE_MODE)
                    && (exit_fuse_mode_i || !pin_sync_r);      // [RULE17]

  // Windowing pair check and answer decode
  assign pair_ok  = ((dur_r ^ ~inv_r) & WIN_PAIR_MASK) == '0;  // [RULE10]
  assign good_ans = wr_answer_i && (wr_data_i == GOOD_ANSWER);
  assign bad_ans  = wr_answer_i && (wr_data_i != GOOD_ANSWER);

  // Release needs debug off, clean counter and the mirror windowing bit
  assign release_ok = wr_release_i && (wr_data_i == RELEASE_KEY)
                    && !debug_r                                // [RULE8]
                    && (fault_r == '0)
                    && (state_r == FSR_NORMAL)
                    && mirror_r[CFG_WDW_EN_BIT];               // [RULE14]

  // Fail-safe state machine
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= FSR_STARTUP;
    end else begin
      case (state_r)
        FSR_STARTUP: begin
          // Strap sampled after the synchroniser has settled
          if (pin_sync_r) begin
            state_r <= FSR_FUSE_MODE;
          end else if (fuse_valid_i) begin
            state_r <= FSR_INIT;                               // [RULE6]
          end else begin
            state_r <= FSR_START_FAIL;                         // [RULE7]
          end
        end
        FSR_FUSE_MODE: begin
          if (leave_fuse) begin
            if (written_r || fuse_valid_i) begin
              state_r <= FSR_INIT;                             // [RULE4]
            end else begin
              state_r <= FSR_START_FAIL;                       // [RULE7]
            end
          end
        end
        FSR_INIT: begin
          // No init timeout is modelled, debug or not
          if (good_ans) begin
            state_r <= FSR_NORMAL;                             // [RULE11]
          end
        end
        FSR_NORMAL:     state_r <= FSR_NORMAL;
        FSR_START_FAIL: state_r <= FSR_START_FAIL;
        default:        state_r <= FSR_START_FAIL;
      endcase
    end
  end

  // Debug mode flag: on with fuse mode, off only by the exit bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      debug_r <= 1'b0;
    end else if (state_r == FSR_STARTUP && pin_sync_r) begin
      debug_r <= 1'b1;                                         // [RULE16]
    end else if (wr_state_reg_i && wr_data_i[DBG_EXIT_BIT]) begin
      debug_r <= 1'b0;                                         // [RULE8]
    end
  end

  // Host-written flag; only meaningful before the fuse-mode exit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      written_r <= 1'b0;
    end else if (wr_mirror_i && state_r == FSR_FUSE_MODE) begin
      written_r <= 1'b1;                                       // [RULE18]
    end
  end

  // Mirror register: host trial data or fuse load
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mirror_r <= CFG_RST;
    end else if (wr_mirror_i && state_r == FSR_FUSE_MODE) begin
      mirror_r <= mirror_data_i;                               // [RULE2]
    end else if (state_r == FSR_STARTUP && !pin_sync_r
                 && fuse_valid_i) begin
      mirror_r <= fuse_cfg_i;                                  // [RULE6]
    end else if (leave_fuse && !written_r && fuse_valid_i) begin
      mirror_r <= fuse_cfg_i;                                  // [RULE6]
    end
    // A written mirror is left untouched on exit                 [RULE5]
  end

  // Watchdog window duration pair
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dur_r <= DUR_RST;
      inv_r <= INV_RST;
    end else begin
      if (wr_window_dur_i) begin
        dur_r <= wr_data_i;
      end
      if (wr_window_inv_i) begin
        inv_r <= wr_data_i;
      end
    end
  end

  // Fault counter: good answers count down once debug is left
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_r <= FAULT_RST;
    end else if (!debug_r && state_r == FSR_NORMAL) begin
      if (good_ans && fault_r != '0) begin
        fault_r <= fault_r - 1'b1;                             // [RULE12]
      end else if (bad_ans && fault_r != FAULT_MAX) begin
        fault_r <= fault_r + 1'b1;                             // [RULE15]
      end
    end
  end

  // Safety output; a bad answer drops it, except in debug mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      release_r <= 1'b0;
    end else if (bad_ans && !debug_r) begin
      release_r <= 1'b0;                                       // [RULE15]
    end else if (release_ok) begin
      release_r <= 1'b1;                                       // [RULE13]
    end
  end

  // Outputs
  assign failsafe_state_o    = state_r;
  assign debug_mode_o        = debug_r;
  assign regulators_en_o     = (state_r == FSR_INIT)
                             || (state_r == FSR_NORMAL);       // [RULE3]
  assign startup_fail_o      = (state_r == FSR_START_FAIL);
  assign active_cfg_o        = mirror_r;                       // [RULE1]
  assign mirror_written_o    = written_r;
  assign window_period_o     =
    dur_r[WIN_PERIOD_LSB +: WIN_PERIOD_W];
  assign window_cfg_ok_o     = pair_ok;
  // Windowing needs a checked nonzero period and no debug
  assign windowing_active_o  = !debug_r && pair_ok
    && (dur_r[WIN_PERIOD_LSB +: WIN_PERIOD_W] != WIN_PERIOD_OFF); // [RULE9]
  assign fault_cnt_o         = fault_r;
  assign safety_output_pin_o = release_r;

endmodule

// ### verif/fsr_checker.sv
// Port-level assertions for the fail-safe release sequencer.
module fsr_checker
  import fsr_pkg::*;
#(
  parameter int unsigned CFG_W = 16
) (
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             debug_entry_pin_i,
  input wire logic             fuse_valid_i,
  input wire logic [CFG_W-1:0] fuse_cfg_i,
  input wire logic [15:0]      wr_data_i,
  input wire logic             wr_window_dur_i,
  input wire logic             wr_window_inv_i,
  input wire logic             wr_answer_i,
  input wire logic             wr_release_i,
  input wire logic             wr_mirror_i,
  input wire logic             wr_state_reg_i,
  input wire logic             exit_fuse_mode_i,
  input wire logic [2:0]       failsafe_state_o,
  input wire logic             debug_mode_o,
  input wire logic             regulators_en_o,
  input wire logic [CFG_W-1:0] active_cfg_o,
  input wire logic             mirror_written_o,
  input wire logic [4:0]       window_period_o,
  input wire logic             window_cfg_ok_o,
  input wire logic             windowing_active_o,
  input wire logic [2:0]       fault_cnt_o,
  input wire logic             safety_output_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Good answer seen on the bus this cycle
  wire good = wr_answer_i && (wr_data_i == GOOD_ANSWER);
  // Duration, then its inverse two cycles later
  sequence s_pair;
    wr_window_dur_i ##2 (wr_window_inv_i && wr_data_i == ~$past(wr_data_i, 2));
  endsequence
  property p_pair; s_pair |=> window_cfg_ok_o; endproperty
  property p_win; windowing_active_o |-> window_cfg_ok_o &&
    window_period_o != 5'h00 && !debug_mode_o; endproperty
  property p_fail; (failsafe_state_o == FSR_STARTUP && !fuse_valid_i &&
    !debug_entry_pin_i && !mirror_written_o) |=>
    failsafe_state_o == FSR_START_FAIL && !regulators_en_o; endproperty
  property p_cfg; (failsafe_state_o == FSR_INIT && !mirror_written_o) |->
    active_cfg_o == fuse_cfg_i; endproperty
  property p_reg; $rose(regulators_en_o) |-> failsafe_state_o == FSR_INIT;
  endproperty
  property p_init; (failsafe_state_o == FSR_INIT && good) |=>
    failsafe_state_o == FSR_NORMAL; endproperty
  property p_dec; (failsafe_state_o == FSR_NORMAL && good && !debug_mode_o &&
    fault_cnt_o != 3'h0) |=> fault_cnt_o == $past(fault_cnt_o) - 3'h1;
  endproperty
  // Fuse mode entered straight from start-up
  sequence s_enter;
    (failsafe_state_o == FSR_STARTUP) ##1 (failsafe_state_o == FSR_FUSE_MODE);
  endsequence
  property p_fuse; failsafe_state_o == FSR_FUSE_MODE |-> !regulators_en_o;
  endproperty
  property p_enter; s_enter |-> debug_mode_o; endproperty
  property p_keep; (failsafe_state_o == FSR_FUSE_MODE && exit_fuse_mode_i &&
    mirror_written_o && !wr_mirror_i) |=> failsafe_state_o == FSR_INIT &&
    active_cfg_o == $past(active_cfg_o); endproperty
  property p_dbgx; (wr_state_reg_i && wr_data_i[DBG_EXIT_BIT] &&
    failsafe_state_o != FSR_STARTUP) |=> !debug_mode_o; endproperty
  property p_rel; $rose(safety_output_pin_o) |-> $past(wr_release_i &&
    wr_data_i == RELEASE_KEY && fault_cnt_o == 3'h0); endproperty
  property p_dbg; $rose(safety_output_pin_o) |-> !$past(debug_mode_o) &&
    active_cfg_o[CFG_WDW_EN_BIT]; endproperty
  a_pair: assert property (p_pair) else $error("pair check");
  a_win: assert property (p_win) else $error("windowing");
  a_fail: assert property (p_fail) else $error("start fail");
  a_cfg: assert property (p_cfg) else $error("cfg src");
  a_reg: assert property (p_reg) else $error("reg start");
  a_init: assert property (p_init) else $error("init close");
  a_dec: assert property (p_dec) else $error("fault dec");
  a_rel: assert property (p_rel) else $error("release");
  a_dbg: assert property (p_dbg) else $error("release gate");
  a_fuse: assert property (p_fuse) else $error("regs in fuse mode");
  a_enter: assert property (p_enter) else $error("debug entry");
  a_keep: assert property (p_keep) else $error("written cfg");
  a_dbgx: assert property (p_dbgx) else $error("debug exit");
endmodule

bind fsr_failsafe_release_sequencer fsr_checker #(.CFG_W(CFG_W)) u_chk (.*);

// ### verif/fsr_host_model.sv
// Host model issuing one-cycle register write strobes.
module fsr_host_model (
  // Clock
  input  wire logic  clk_i,
  // Write data and strobes
  output logic [15:0] data_o,
  output logic [15:0] mdata_o,
  output logic [6:0]  stb_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial begin
    data_o = 16'h0000;
    mdata_o = 16'h0000;
    stb_o = 7'h00;
  end
  // One write; data inverted after release so stale values never match
  task automatic put(input int k, input logic [15:0] d);
    @(negedge clk_i);
    data_o = d;
    mdata_o = d;
    stb_o[k] = 1'b1;
    @(negedge clk_i);
    stb_o = 7'h00;
    data_o = ~d;
    mdata_o = ~d;
  endtask
endmodule

// ### verif/tb.sv
// Self-checking bench for the fail-safe release sequencer.
module tb
  import fsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        debug_entry_pin_i = 1'b0;
  logic        fuse_valid_i = 1'b0;
  logic [15:0] fuse_cfg_i = 16'h0000;
  logic [15:0] wr_data_i, mirror_data_i, active_cfg_o;
  logic [6:0]  stb;
  logic        wr_mirror_i, wr_state_reg_i, wr_window_dur_i, wr_window_inv_i;
  logic        wr_answer_i, wr_release_i, exit_fuse_mode_i;
  logic [2:0]  failsafe_state_o, fault_cnt_o;
  logic        debug_mode_o, regulators_en_o, startup_fail_o, mirror_written_o;
  logic        window_cfg_ok_o, windowing_active_o, safety_output_pin_o;
  logic [4:0]  window_period_o;
  int          error_cnt = 0;
  int          tests_run = 0;
  // Strobe vector split onto the design pins
  assign {exit_fuse_mode_i, wr_release_i, wr_answer_i, wr_window_inv_i,
          wr_window_dur_i, wr_state_reg_i, wr_mirror_i} = stb;
  fsr_host_model u_host (.clk_i(clk_i), .data_o(wr_data_i),
                         .mdata_o(mirror_data_i), .stb_o(stb));
  fsr_failsafe_release_sequencer u_dut (.*);
  // Free-running clock
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk(input logic [15:0] g, e, input string m);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic test_done;
    $display("tests %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Reset with a given fuse content; values checked while held
  task automatic boot(input logic v, input logic [15:0] c);
    @(negedge clk_i);
    rst_i = 1'b1;
    fuse_valid_i = v;
    fuse_cfg_i = c;
    repeat (6) @(negedge clk_i);
    chk(fault_cnt_o, 16'h0006, "fault rst");
    chk(window_cfg_ok_o, 16'h0001, "pair rst");
    rst_i = 1'b0;
    repeat (2) @(negedge clk_i);
  endtask
  // Main sequence: failed start, then release with windowing off and on
  initial begin
    boot(1'b0, 16'h0001);
    chk(failsafe_state_o, FSR_START_FAIL, "no cfg");
    chk(regulators_en_o, 16'h0000, "regs off");
    chk(startup_fail_o, 16'h0001, "fail flag");
    $display("test start fail done");
    // Debug entry with no fuses: written mirror used, debug holds release until exit
    debug_entry_pin_i = 1'b1;
    boot(1'b0, 16'h0000);
    chk(failsafe_state_o, FSR_FUSE_MODE, "fuse mode");
    chk(debug_mode_o, 16'h0001, "dbg on");
    chk(regulators_en_o, 16'h0000, "regs held");
    u_host.put(0, 16'h0003);
    chk(mirror_written_o, 16'h0001, "written");
    u_host.put(6, 16'h0000);
    chk(failsafe_state_o, FSR_INIT, "exit cmd");
    chk(active_cfg_o, 16'h0003, "trial cfg");
    u_host.put(4, GOOD_ANSWER);
    chk(failsafe_state_o, FSR_NORMAL, "dbg init");
    u_host.put(4, 16'h0000);
    chk(fault_cnt_o, 16'h0006, "dbg no fault");
    u_host.put(5, RELEASE_KEY);
    chk(safety_output_pin_o, 16'h0000, "dbg hold");
    u_host.put(1, 16'h4000);
    chk(debug_mode_o, 16'h0000, "dbg exit");
    $display("test written mirror done");
    // Pin removal leaves fuse mode with the burned configuration
    boot(1'b1, 16'h0001);
    debug_entry_pin_i = 1'b0;
    repeat (3) @(negedge clk_i);
    chk(failsafe_state_o, FSR_INIT, "pin exit");
    chk(active_cfg_o, 16'h0001, "fused cfg");
    // Nothing written and nothing burned: exit cannot start up
    debug_entry_pin_i = 1'b1;
    boot(1'b0, 16'h0000);
    u_host.put(6, 16'h0000);
    chk(startup_fail_o, 16'h0001, "fuse exit fail");
    debug_entry_pin_i = 1'b0;
    $display("test fuse exit done");
    for (int c = 0; c < 2; c++) begin
      boot(1'b1, 16'(c));
      chk(failsafe_state_o, FSR_INIT, "init");
      chk(regulators_en_o, 16'h0001, "regs on");
      chk(active_cfg_o, 16'(c), "fuse cfg");
      u_host.put(0, 16'hA5A4);
      chk(active_cfg_o, 16'(c), "mirror lock");
      chk(mirror_written_o, 16'h0000, "written");
      u_host.put(2, 16'h0000);
      chk(windowing_active_o, 16'h0000, "period 0");
      u_host.put(2, 16'h020B);
      chk(window_cfg_ok_o, 16'h0000, "half pair");
      chk(window_period_o, 16'h0000, "period");
      u_host.put(3, 16'hFD04);
      chk(window_cfg_ok_o, 16'h0001, "pair");
      chk(windowing_active_o, 16'h0000, "win off");
      u_host.put(2, 16'h820B);
      u_host.put(3, 16'h7DF4);
      chk(window_period_o, 16'h0010, "period set");
      chk(windowing_active_o, 16'h0001, "win on");
      u_host.put(5, RELEASE_KEY);
      chk(safety_output_pin_o, 16'h0000, "early rel");
      u_host.put(4, GOOD_ANSWER);
      chk(failsafe_state_o, FSR_NORMAL, "normal");
      u_host.put(1, 16'h4000);
      chk(debug_mode_o, 16'h0000, "dbg exit");
      for (int i = 0; i < 6; i++) begin
        u_host.put(4, GOOD_ANSWER);
        chk(fault_cnt_o, 16'(5 - i), "fault");
      end
      u_host.put(5, 16'hB2A4);
      chk(safety_output_pin_o, 16'h0000, "bad key");
      u_host.put(5, RELEASE_KEY);
      chk(safety_output_pin_o, 16'(c), "release");
      u_host.put(4, 16'h0000);
      chk(safety_output_pin_o, 16'h0000, "bad ans");
      chk(fault_cnt_o, 16'h0001, "fault up");
      $display("test release cfg %0d done", c);
    end
    test_done;
  end
  // Watchdog against a hang
  initial begin
    #20us;
    error_cnt++;
    test_done;
  end
endmodule
